/* inc/dscd_pkg.sv */
// Constants, types and helpers for the switch configuration decoder
package dscd_pkg;
	// Register byte offsets
	localparam logic [7:0] DSCD_OFS_CFG = 8'h00;
	localparam logic [7:0] DSCD_OFS_SOFT_ADDR = 8'h04;
	localparam logic [7:0] DSCD_OFS_NVM_BAUD = 8'h08;
	localparam logic [7:0] DSCD_OFS_SW_BAUD = 8'h0c;
	localparam logic [7:0] DSCD_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] DSCD_OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] DSCD_OFS_RAW_SW = 8'h18;

	// CFG register field positions
	localparam int DSCD_CFG_CLAMP_LSB = 0;
	localparam int DSCD_CFG_CLAMP_BAD = 4;
	localparam int DSCD_CFG_BAUD_SW = 5;
	localparam int DSCD_CFG_TWO_WIRE = 6;
	localparam int DSCD_CFG_MULTIDROP = 7;
	localparam int DSCD_CFG_TX_TERM = 8;
	localparam int DSCD_CFG_RX_TERM = 9;
	localparam int DSCD_CFG_ADDR_SW = 10;
	localparam int DSCD_CFG_VALID = 11;
	localparam int DSCD_CFG_ADDR_LSB = 16;

	// Interrupt status bits
	localparam int DSCD_IRQ_CAPTURED = 0;
	localparam int DSCD_IRQ_CLAMP_BAD = 1;
	localparam int DSCD_IRQ_W = 2;

	// Reset values
	localparam logic [5:0] DSCD_SOFT_ADDR_RST = 6'h01;
	localparam logic [3:0] DSCD_NVM_BAUD_RST = 4'h0;
	localparam logic [3:0] DSCD_SW_BAUD_RST = 4'h0;
	localparam logic [DSCD_IRQ_W-1:0] DSCD_IRQ_MASK_RST = 2'h0;

	// Switch bus layout: clamp 3:0, function switches 13:4, interface select 14
	localparam int DSCD_SW_W = 15;
	localparam int DSCD_FN_LSB = 4;
	localparam int DSCD_SEL_BIT = 14;

	// Settling time after reset before switches are captured
	localparam int DSCD_CLK_MHZ = 125;
	localparam int DSCD_SETTLE_NS = 1000;
	localparam int DSCD_SETTLE_CYC = (DSCD_SETTLE_NS * DSCD_CLK_MHZ + 999) / 1000;
	localparam int DSCD_CNT_W = 8;

	typedef enum logic [2:0] {
		DSCD_ST_WAIT = 3'b001,
		DSCD_ST_SETTLE = 3'b010,
		DSCD_ST_HOLD = 3'b100
	} dscd_cap_e;

	function automatic logic dscd_onehot4(input logic [3:0] v);
		dscd_onehot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
	endfunction : dscd_onehot4
endpackage : dscd_pkg

/* inc/dscd_cfg_if.sv */
// Captured switch settings passed from capture logic to the top
interface dscd_cfg_if;
	logic [3:0] clamp;
	logic clamp_bad;
	logic baud_sw;
	logic two_wire;
	logic [5:0] addr;
	logic tx_term;
	logic rx_term;
	logic multidrop;
	logic valid;
	logic captured;

	modport producer (output clamp, clamp_bad, baud_sw, two_wire, addr, tx_term, rx_term,
		multidrop, valid, captured);
	modport consumer (input clamp, clamp_bad, baud_sw, two_wire, addr, tx_term, rx_term,
		multidrop, valid, captured);
endinterface : dscd_cfg_if

/* rtl/dscd_sync.sv */
// Two-stage synchroniser for the switch pins
module dscd_sync
	import dscd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [DSCD_SW_W-1:0] pins,
	output logic [DSCD_SW_W-1:0] synced
);
	logic [DSCD_SW_W-1:0] meta_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			synced <= '0;
		end else begin
			meta_q <= pins;
			synced <= meta_q;
		end
	end
endmodule : dscd_sync

/* rtl/dscd_capture.sv */
// One-shot capture and decode of the synchronised switches
module dscd_capture
	import dscd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [DSCD_SW_W-1:0] sw,
	dscd_cfg_if.producer cfg
);
	dscd_cap_e state_q;
	logic [DSCD_CNT_W-1:0] cnt_q;

	localparam logic [DSCD_CNT_W-1:0] SETTLE_LAST = DSCD_CNT_W'(DSCD_SETTLE_CYC - 1);

	// Waits out the synchroniser and switch settling, then freezes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= DSCD_ST_WAIT;
			cnt_q <= '0;
		end else begin
			case (state_q)
				DSCD_ST_WAIT: state_q <= DSCD_ST_SETTLE;
				DSCD_ST_SETTLE: begin
					if (cnt_q == SETTLE_LAST) begin
						state_q <= DSCD_ST_HOLD;
					end else begin
						cnt_q <= cnt_q + DSCD_CNT_W'(1);
					end
				end
				DSCD_ST_HOLD: state_q <= DSCD_ST_HOLD;
				default: state_q <= DSCD_ST_WAIT;
			endcase
		end
	end

	// Settings latched once; later switch moves are ignored until reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg.clamp <= 4'h0;
			cfg.clamp_bad <= 1'b0;
			cfg.baud_sw <= 1'b0;
			cfg.two_wire <= 1'b0;
			cfg.addr <= 6'h00;
			cfg.tx_term <= 1'b0;
			cfg.rx_term <= 1'b0;
			cfg.multidrop <= 1'b0;
			cfg.valid <= 1'b0;
			cfg.captured <= 1'b0;
		end else begin
			cfg.captured <= 1'b0;
			if (state_q == DSCD_ST_SETTLE && cnt_q == SETTLE_LAST) begin
				cfg.clamp <= sw[3:0];
				cfg.clamp_bad <= !dscd_onehot4(sw[3:0]);
				cfg.baud_sw <= sw[DSCD_FN_LSB];
				cfg.two_wire <= sw[DSCD_FN_LSB + 1];
				cfg.addr <= sw[DSCD_FN_LSB + 7:DSCD_FN_LSB + 2];
				cfg.tx_term <= sw[DSCD_FN_LSB + 8];
				cfg.rx_term <= sw[DSCD_FN_LSB + 9];
				cfg.multidrop <= sw[DSCD_SEL_BIT];
				cfg.valid <= 1'b1;
				cfg.captured <= 1'b1;
			end
		end
	end
endmodule : dscd_capture

/* rtl/dscd_top.sv */
// Switch bank configuration decoder with AHB-Lite register access
module dscd_top
	import dscd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] clamp_sw,
	input wire logic [9:0] func_sw,
	input wire logic interface_select_switch,
	output logic [3:0] clamp_thr_q,
	output logic clamp_invalid_q,
	output logic baud_from_nvm_q,
	output logic [3:0] baud_code_q,
	output logic two_wire_q,
	output logic [5:0] node_addr_q,
	output logic multidrop_sel_q,
	output logic p2p_sel_q,
	output logic tx_term_en_q,
	output logic rx_term_en_q,
	output logic irq_q
);
	logic [DSCD_SW_W-1:0] sw_sync;
	dscd_cfg_if cfg_bus ();

	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic [5:0] soft_addr_q;
	logic [3:0] nvm_baud_q;
	logic [3:0] sw_baud_q;
	logic [DSCD_IRQ_W-1:0] irq_stat_q;
	logic [DSCD_IRQ_W-1:0] irq_mask_q;
	logic [DSCD_IRQ_W-1:0] irq_set;
	logic [DSCD_IRQ_W-1:0] irq_clr;
	logic [31:0] cfg_word;
	logic [31:0] rd_mux;
	logic addr_take;
	logic wr_now;
	logic addr_from_sw;

	dscd_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pins({interface_select_switch, func_sw, clamp_sw}),
		.synced(sw_sync)
	);

	dscd_capture u_capture (
		.hclk(hclk),
		.hresetn(hresetn),
		.sw(sw_sync),
		.cfg(cfg_bus.producer)
	);

	// Bus: writes are zero-wait, reads take one wait state so data comes from a flop
	assign addr_take = hsel && hready && htrans[1];
	assign wr_now = wr_pend_q;

	function automatic logic dscd_wr_hit(input logic en, input logic [7:0] a,
		input logic [7:0] ofs);
		dscd_wr_hit = en && (a == ofs);
	endfunction : dscd_wr_hit

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
			end else if (addr_take) begin
				wr_pend_q <= hwrite;
				rd_pend_q <= !hwrite;
				addr_q <= {haddr[7:2], 2'b00};
			end else begin
				wr_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else if (rd_pend_q) begin
			hreadyout <= 1'b1;
		end else if (addr_take) begin
			hreadyout <= hwrite;
		end
	end

	// No error responses exist, but the output still leaves a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	assign addr_from_sw = cfg_bus.addr != 6'h00;

	always_comb begin
		cfg_word = 32'h0000_0000;
		cfg_word[DSCD_CFG_CLAMP_LSB +: 4] = cfg_bus.clamp;
		cfg_word[DSCD_CFG_CLAMP_BAD] = cfg_bus.clamp_bad;
		cfg_word[DSCD_CFG_BAUD_SW] = cfg_bus.baud_sw;
		cfg_word[DSCD_CFG_TWO_WIRE] = cfg_bus.two_wire;
		cfg_word[DSCD_CFG_MULTIDROP] = cfg_bus.multidrop;
		cfg_word[DSCD_CFG_TX_TERM] = cfg_bus.tx_term;
		cfg_word[DSCD_CFG_RX_TERM] = cfg_bus.rx_term;
		cfg_word[DSCD_CFG_ADDR_SW] = addr_from_sw;
		cfg_word[DSCD_CFG_VALID] = cfg_bus.valid;
		cfg_word[DSCD_CFG_ADDR_LSB +: 6] = node_addr_q;
	end

	always_comb begin
		case (addr_q)
			DSCD_OFS_CFG: rd_mux = cfg_word;
			DSCD_OFS_SOFT_ADDR: rd_mux = {26'h0, soft_addr_q};
			DSCD_OFS_NVM_BAUD: rd_mux = {28'h0, nvm_baud_q};
			DSCD_OFS_SW_BAUD: rd_mux = {28'h0, sw_baud_q};
			DSCD_OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
			DSCD_OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_q};
			DSCD_OFS_RAW_SW: rd_mux = {17'h0, sw_sync};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend_q) begin
			hrdata <= rd_mux;
		end
	end

	// Software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_addr_q <= DSCD_SOFT_ADDR_RST;
		end else if (dscd_wr_hit(wr_now, addr_q, DSCD_OFS_SOFT_ADDR)) begin
			soft_addr_q <= hwdata[5:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nvm_baud_q <= DSCD_NVM_BAUD_RST;
		end else if (dscd_wr_hit(wr_now, addr_q, DSCD_OFS_NVM_BAUD)) begin
			nvm_baud_q <= hwdata[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_baud_q <= DSCD_SW_BAUD_RST;
		end else if (dscd_wr_hit(wr_now, addr_q, DSCD_OFS_SW_BAUD)) begin
			sw_baud_q <= hwdata[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= DSCD_IRQ_MASK_RST;
		end else if (dscd_wr_hit(wr_now, addr_q, DSCD_OFS_IRQ_MASK)) begin
			irq_mask_q <= hwdata[DSCD_IRQ_W-1:0];
		end
	end

	// Sticky events, write one to clear; a new event beats a clear
	always_comb begin
		irq_set = '0;
		irq_set[DSCD_IRQ_CAPTURED] = cfg_bus.captured;
		irq_set[DSCD_IRQ_CLAMP_BAD] = cfg_bus.captured && cfg_bus.clamp_bad;
		irq_clr = '0;
		if (dscd_wr_hit(wr_now, addr_q, DSCD_OFS_IRQ_STAT)) begin
			irq_clr = hwdata[DSCD_IRQ_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Clamp threshold: an illegal pattern selects nothing, so the brake never fires wrong
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clamp_thr_q <= 4'h0;
		end else begin
			clamp_thr_q <= (cfg_bus.valid && !cfg_bus.clamp_bad) ? cfg_bus.clamp : 4'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clamp_invalid_q <= 1'b0;
		end else begin
			clamp_invalid_q <= cfg_bus.valid && cfg_bus.clamp_bad;
		end
	end

	// Multi-drop link settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_from_nvm_q <= 1'b1;
		end else begin
			baud_from_nvm_q <= !cfg_bus.baud_sw;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_code_q <= DSCD_NVM_BAUD_RST;
		end else begin
			baud_code_q <= cfg_bus.baud_sw ? sw_baud_q : nvm_baud_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			two_wire_q <= 1'b0;
		end else begin
			two_wire_q <= cfg_bus.two_wire;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			node_addr_q <= DSCD_SOFT_ADDR_RST;
		end else begin
			node_addr_q <= addr_from_sw ? cfg_bus.addr : soft_addr_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_term_en_q <= 1'b0;
		end else begin
			tx_term_en_q <= cfg_bus.tx_term;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_term_en_q <= 1'b0;
		end else begin
			rx_term_en_q <= cfg_bus.rx_term;
		end
	end

	// Point-to-point stays selected until a capture says otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			multidrop_sel_q <= 1'b0;
		end else begin
			multidrop_sel_q <= cfg_bus.multidrop;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p2p_sel_q <= 1'b1;
		end else begin
			p2p_sel_q <= !cfg_bus.multidrop;
		end
	end
endmodule : dscd_top

/* verif/dscd_switch_bank.sv */
// Operator-set switch banks facing the decoder
module dscd_switch_bank
	import dscd_pkg::*;
(
	input wire logic [DSCD_SW_W-1:0] setting,
	output logic [3:0] clamp_sw,
	output logic [9:0] func_sw,
	output logic interface_select_switch
);
	timeunit 1ns;
	timeprecision 1ps;
	// Of the terminated 2-wire cases, 10'h1af keeps switch ten off and 10'h302 sets it
	assign clamp_sw = setting[3:0];
	assign func_sw = setting[13:4];
	assign interface_select_switch = setting[DSCD_SEL_BIT];
endmodule : dscd_switch_bank

/* verif/dscd_monitor.sv */
// Port-level checker for the switch configuration decoder
module dscd_monitor
	import dscd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [3:0] clamp_sw,
	input wire logic [9:0] func_sw,
	input wire logic interface_select_switch,
	input wire logic [3:0] clamp_thr_q,
	input wire logic clamp_invalid_q,
	input wire logic baud_from_nvm_q,
	input wire logic two_wire_q,
	input wire logic [5:0] node_addr_q,
	input wire logic multidrop_sel_q,
	input wire logic p2p_sel_q,
	input wire logic tx_term_en_q,
	input wire logic rx_term_en_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic cap;
	logic [7:0] cyc_q;
	// Every capture leaves either a threshold or the invalid flag
	assign cap = (clamp_thr_q != 4'h0) || clamp_invalid_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cyc_q <= 8'h00;
		else if (cyc_q != 8'hff)
			cyc_q <= cyc_q + 8'h01;
	end
	a_clamp_decode: assert property ($rose(cap) |->
		clamp_thr_q == ($onehot(clamp_sw) ? clamp_sw : 4'h0)) else $error("clamp threshold wrong");
	a_clamp_flag: assert property ($rose(cap) |->
		clamp_invalid_q != $onehot(clamp_sw)) else $error("clamp invalid flag wrong");
	a_baud_src: assert property ($rose(cap) |-> baud_from_nvm_q == !func_sw[0])
		else $error("baud source wrong");
	a_wire_mode: assert property ($rose(cap) |-> two_wire_q == func_sw[1])
		else $error("wiring mode wrong");
	a_addr_switch: assert property ($rose(cap) && func_sw[7:2] != 6'h00 |->
		node_addr_q == func_sw[7:2]) else $error("switch address wrong");
	a_term_enables: assert property ($rose(cap) |->
		{rx_term_en_q, tx_term_en_q} == func_sw[9:8]) else $error("termination wrong");
	a_if_select: assert property ($rose(cap) |-> multidrop_sel_q == interface_select_switch
		&& p2p_sel_q == !interface_select_switch) else $error("interface select wrong");
	a_cfg_held: assert property (cap |=> $stable({clamp_thr_q, clamp_invalid_q, two_wire_q,
		tx_term_en_q, rx_term_en_q, multidrop_sel_q})) else $error("settings moved");
	a_capture_due: assert property (cyc_q == 8'd160 |-> cap)
		else $error("no capture");
	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
endmodule : dscd_monitor

bind dscd_top dscd_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .clamp_sw(clamp_sw),
	.func_sw(func_sw), .interface_select_switch(interface_select_switch),
	.clamp_thr_q(clamp_thr_q), .clamp_invalid_q(clamp_invalid_q),
	.baud_from_nvm_q(baud_from_nvm_q), .two_wire_q(two_wire_q), .node_addr_q(node_addr_q),
	.multidrop_sel_q(multidrop_sel_q), .p2p_sel_q(p2p_sel_q), .tx_term_en_q(tx_term_en_q),
	.rx_term_en_q(rx_term_en_q));

/* verif/dscd_top_tb.sv */
// Self-checking bench for the switch configuration decoder
module dscd_top_tb
	import dscd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [14:0] setting = 15'h0;
	logic [31:0] hrdata, rd, snap;
	logic hreadyout, hresp, clamp_invalid_q, baud_from_nvm_q, two_wire_q, irq_q;
	logic multidrop_sel_q, p2p_sel_q, tx_term_en_q, rx_term_en_q, interface_select_switch;
	logic [3:0] clamp_sw, clamp_thr_q, baud_code_q;
	logic [9:0] func_sw;
	logic [5:0] node_addr_q;
	int bad_count = 0;
	int tests_run = 0;
	logic [14:0] cases [6] = '{{1'b1, 10'h1af, 4'h1}, {1'b0, 10'h200, 4'h2},
		{1'b1, 10'h004, 4'h4}, {1'b0, 10'h0fe, 4'h8}, {1'b0, 10'h302, 4'h3},
		{1'b1, 10'h080, 4'h0}};

	initial begin
		forever #4 hclk = ~hclk;
	end

	dscd_switch_bank u_bank (.setting(setting), .clamp_sw(clamp_sw), .func_sw(func_sw),
		.interface_select_switch(interface_select_switch));
	dscd_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .clamp_sw(clamp_sw), .func_sw(func_sw),
		.interface_select_switch(interface_select_switch), .clamp_thr_q(clamp_thr_q),
		.clamp_invalid_q(clamp_invalid_q), .baud_from_nvm_q(baud_from_nvm_q),
		.baud_code_q(baud_code_q), .two_wire_q(two_wire_q), .node_addr_q(node_addr_q),
		.multidrop_sel_q(multidrop_sel_q), .p2p_sel_q(p2p_sel_q), .tx_term_en_q(tx_term_en_q),
		.rx_term_en_q(rx_term_en_q), .irq_q(irq_q));

	task finish_test;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Waits for an edge with hready high; a stuck bus ends the run
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_rdy

	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus

	task run(input logic [14:0] v);
		int n;
		logic bad;
		bad = $countones(v[3:0]) != 1;
		setting <= v;
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({multidrop_sel_q, p2p_sel_q}, 2'b01);
		bus(1'b1, DSCD_OFS_SOFT_ADDR, 32'h2a);
		bus(1'b1, DSCD_OFS_NVM_BAUD, 32'h5);
		bus(1'b1, DSCD_OFS_SW_BAUD, 32'ha);
		n = 0;
		do begin
			bus(1'b0, DSCD_OFS_CFG, 32'h0);
			n++;
		end while (rd[DSCD_CFG_VALID] !== 1'b1 && n < 100);
		chk(n < 100, 1'b1);
		if (n >= 100) begin
			finish_test();
		end
		repeat (2) @(posedge hclk);
		chk(clamp_thr_q, bad ? 4'h0 : v[3:0]);
		chk(clamp_invalid_q, bad);
		chk(baud_from_nvm_q, !v[4]);
		chk(baud_code_q, v[4] ? 4'ha : 4'h5);
		chk(two_wire_q, v[5]);
		chk(node_addr_q, v[11:6] != 6'h00 ? v[11:6] : 6'h2a);
		chk({rx_term_en_q, tx_term_en_q}, v[13:12]);
		chk({multidrop_sel_q, p2p_sel_q}, {v[14], !v[14]});
		bus(1'b0, DSCD_OFS_IRQ_STAT, 32'h0);
		chk(rd, {30'h0, bad, 1'b1});
		bus(1'b0, DSCD_OFS_RAW_SW, 32'h0);
		chk(rd, {17'h0, v});
		bus(1'b0, DSCD_OFS_SW_BAUD, 32'h0);
		chk(rd, 32'h0000_000a);
		chk(irq_q, 1'b0);
		bus(1'b1, DSCD_OFS_IRQ_MASK, 32'h3);
		repeat (2) @(posedge hclk);
		chk(irq_q, 1'b1);
		bus(1'b1, DSCD_OFS_IRQ_STAT, 32'h3);
		repeat (2) @(posedge hclk);
		chk(irq_q, 1'b0);
		snap = {clamp_thr_q, clamp_invalid_q, two_wire_q, node_addr_q, tx_term_en_q, p2p_sel_q};
		setting <= ~v;
		repeat (10) @(posedge hclk);
		chk({clamp_thr_q, clamp_invalid_q, two_wire_q, node_addr_q, tx_term_en_q, p2p_sel_q}, snap);
	endtask : run

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, DSCD_OFS_SOFT_ADDR, 32'h0);
		chk(rd, {26'h0, DSCD_SOFT_ADDR_RST});
		bus(1'b0, DSCD_OFS_IRQ_MASK, 32'h0);
		chk(rd, {30'h0, DSCD_IRQ_MASK_RST});
		bus(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, DSCD_OFS_CFG, 32'h0);
		snap = rd;
		bus(1'b1, DSCD_OFS_CFG, 32'hffffffff);
		bus(1'b0, DSCD_OFS_CFG, 32'h0);
		chk(rd, snap);
		foreach (cases[i])
			run(cases[i]);
		finish_test();
	end
endmodule : dscd_top_tb
